// ==== design/asdl_pkg.sv ====
/*
 * asdl_pkg: constants of the adc sequencer and dac load control block.
 * assumes a 40 MHz sys_clk and a 16-bit internal register port.
 */
package asdl_pkg;
  // ==========================================================================
  // sizes
  localparam int NUM_DAC = 8;
  localparam int NUM_CH  = 9;
  localparam int CH_W    = 4;
  localparam int RES_W   = 12;
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 6;

  // ==========================================================================
  // register addresses
  localparam logic [5:0] A_RES0    = 6'h00;
  localparam logic [5:0] A_RES_END = 6'h09;
  localparam logic [5:0] A_DAC_CFG = 6'h09;
  localparam logic [5:0] A_STATUS  = 6'h0A;
  localparam logic [5:0] A_ADC_CTL = 6'h0B;
  localparam logic [5:0] A_LOAD    = 6'h0C;
  localparam logic [5:0] A_DAC0    = 6'h10;

  // ==========================================================================
  // fields and reset values
  localparam int CTL_MODE_BIT  = 15;
  localparam int CTL_SA_LSB    = 8;
  localparam int CTL_EA_LSB    = 4;
  localparam logic [15:0] CTL_RANGE_MASK = 16'h0FF0;
  localparam logic [15:0] CTL_RST        = 16'h0000;
  localparam int STAT_TRIG_BIT = 5;
  localparam int STAT_DATA_AVAIL_FLAG_BIT = 13;
  localparam int CFG_SLD_LSB   = 8;
  localparam int CFG_GAIN_LSB  = 0;
  localparam logic [15:0] LOAD_MAGIC = 16'hBB00;
  localparam logic [3:0]  CH_TEMP    = 4'h8;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ      = 40;
  localparam int DAV_PULSE_NS = 2000;
  localparam int DAV_CYC      = (DAV_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int DAV_CNT_W    = 7;
endpackage

// ==== design/asdl_seq_if.sv ====
/*
 * asdl_seq_if: signals between the register side and the conversion sequencer.
 * assumes both ends run on the same sys_clk.
 */
`timescale 1ns/1ps
interface asdl_seq_if;
  logic        start;
  logic        halt;
  logic        repeat_en;
  logic [3:0]  first_ch;
  logic [3:0]  last_ch;
  logic        conv_start;
  logic [3:0]  conv_ch;
  logic        conv_done;
  logic [11:0] conv_data;
  logic        smp_valid;
  logic [3:0]  smp_ch;
  logic [11:0] smp_data;
  logic        pass_done;
  logic        busy;

  modport ctrl (output start, halt, repeat_en, first_ch, last_ch, conv_done, conv_data,
                input conv_start, conv_ch, smp_valid, smp_ch, smp_data, pass_done, busy);
  modport seq  (input start, halt, repeat_en, first_ch, last_ch, conv_done, conv_data,
                output conv_start, conv_ch, smp_valid, smp_ch, smp_data, pass_done, busy);
endinterface

// ==== design/asdl_seq.sv ====
/*
 * asdl_seq: walks the channel range, one conversion request at a time.
 * assumes the converter answers each conv_start with one conv_done.
 */
`timescale 1ns/1ps
module asdl_seq (
  input wire logic sys_clk,
  input wire logic rst,
  asdl_seq_if.seq  sq
);
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} asdl_state_t;

  asdl_state_t state_r;
  logic [3:0]  ch_r;

  wire last_hit = (ch_r == sq.last_ch);
  wire done_in  = (state_r == S_WAIT) && sq.conv_done;

  assign sq.conv_start = (state_r == S_ISSUE);
  assign sq.conv_ch    = ch_r;
  assign sq.busy       = (state_r != S_IDLE);
  assign sq.smp_valid  = done_in;
  assign sq.smp_ch     = ch_r;
  assign sq.smp_data   = sq.conv_data;
  assign sq.pass_done  = done_in && last_hit;

  // ==========================================================================
  // sequence state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= S_IDLE;
      ch_r    <= 4'h0;
    end else if (sq.start) begin
      state_r <= S_ISSUE;
      ch_r    <= sq.first_ch;
    end else if (sq.halt) begin
      state_r <= S_IDLE;
    end else begin
      unique case (state_r)
        S_IDLE:  state_r <= S_IDLE;
        S_ISSUE: state_r <= S_WAIT;
        S_WAIT: begin
          if (done_in && last_hit) begin
            ch_r    <= sq.first_ch;
            state_r <= sq.repeat_en ? S_ISSUE : S_IDLE;
          end else if (done_in) begin
            ch_r    <= ch_r + 4'h1;
            state_r <= S_ISSUE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_wrap;
    sq.pass_done && sq.repeat_en && !sq.start && !sq.halt
      |=> sq.conv_start && sq.conv_ch == $past(sq.first_ch);
  endproperty
  a_wrap: assert property (p_wrap) else $error("repeat pass did not wrap to start");

  property p_oneshot;
    sq.pass_done && !sq.repeat_en && !sq.start |=> !sq.busy [*2];
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot pass did not go idle");
endmodule

// ==== design/asdl_top.sv ====
/*
 * asdl_top: dac gain and load-strobe control, adc sequencing and result registers.
 * assumes a serial front end that turns host frames into one-cycle reg_wr and
 * reg_rd pulses with address and data on sys_clk; converter logic on sys_clk.
 */
// How it works
// - each dac gain bit set means buffer gain two, clear means gain one.
// - writing 0xBB00 to the load register makes one internal load strobe.
// - internal strobe copies data to latch only for sync-load enabled channels.
// - any other load register value makes no strobe and changes no dac.
// - load register clears after its strobe, and on reset.
// - with internal trigger, every control write starts a sequence.
// - with external trigger, a control write only records the channel range.
// - repeat mode bit is forced to zero while external trigger is selected.
// - one-shot converts start through end ascending once, then idles.
// - repeat mode returns from end channel to start and continues.
// - repeating stops on a one-shot control write or external trigger enable.
// - channel codes zero to eight are binary, code eight is the temperature sensor.
// - control holds mode at bit 15, start at 11:8, end at 7:4.
// - control register resets to zero.
// - nine result registers hold 12-bit result and 4-bit channel number.
// - results update when the end channel conversion completes.
// - result registers are read-only and reset to zero.
// - external convert rising edge starts one pass when external trigger set.
// - sync-load clear channel updates latch on data write, ignores strobes.
// - repeat mode pulses data-available low 2 us at each end channel.
`timescale 1ns/1ps
module asdl_top (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [5:0]   reg_addr,
  input  wire logic [15:0]  reg_wdata,
  output logic      [15:0]  reg_rdata,
  output logic              reg_rvalid,
  input  wire logic         convert_in,
  input  wire logic         ext_load_in,
  output logic      [95:0]  dac_latch_out,
  output logic      [7:0]   dac_buffer_gain_sel,
  output logic              adc_start,
  output logic      [3:0]   adc_channel,
  output logic              temp_sensor_channel,
  input  wire logic         adc_done,
  input  wire logic [11:0]  adc_data,
  output logic              data_avail_n
);
  localparam int NDAC = asdl_pkg::NUM_DAC;
  localparam int NCH  = asdl_pkg::NUM_CH;

  asdl_seq_if sq ();

  asdl_seq u_seq (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sq      (sq)
  );

  // ==========================================================================
  // pin synchronisers: bit 0 convert, bit 1 external load
  logic [1:0] s1_r, s2_r, s3_r, lvl_r;
  wire  [1:0] agree   = s2_r ~^ s3_r;
  wire  [1:0] lvl_nxt = (agree & s3_r) | (~agree & lvl_r);
  wire  [1:0] rise    = lvl_nxt & ~lvl_r;
  wire        cnv_rise = rise[0];
  wire        eld_rise = rise[1];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r  <= 2'h0;
      s2_r  <= 2'h0;
      s3_r  <= 2'h0;
      lvl_r <= 2'h0;
    end else begin
      s1_r  <= {ext_load_in, convert_in};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // ==========================================================================
  // write decode
  wire wr_load = reg_wr && (reg_addr == asdl_pkg::A_LOAD);
  wire wr_ctl  = reg_wr && (reg_addr == asdl_pkg::A_ADC_CTL);
  wire wr_stat = reg_wr && (reg_addr == asdl_pkg::A_STATUS);
  wire wr_cfg  = reg_wr && (reg_addr == asdl_pkg::A_DAC_CFG);
  wire dac_hit = (reg_addr[5:3] == asdl_pkg::A_DAC0[5:3]);
  wire res_hit = (reg_addr < asdl_pkg::A_RES_END);
  wire wr_dac  = reg_wr && dac_hit;
  wire rd_res  = reg_rd && res_hit;

  // ==========================================================================
  // configuration, trigger source, control
  logic [15:0] cfg_r, ctl_r, load_r;
  logic        trig_r, data_avail_flag_r, dav_n_r;
  logic [6:0]  dav_cnt_r;

  wire [7:0]  sld = cfg_r[asdl_pkg::CFG_SLD_LSB +: NDAC];
  wire        trig_nxt = wr_stat ? reg_wdata[asdl_pkg::STAT_TRIG_BIT] : trig_r;
  wire        wr_mode  = reg_wdata[asdl_pkg::CTL_MODE_BIT] & ~trig_nxt;
  wire [15:0] ctl_wval = (reg_wdata & asdl_pkg::CTL_RANGE_MASK)
                       | (16'(wr_mode) << asdl_pkg::CTL_MODE_BIT);
  wire        keep_mode = ctl_r[asdl_pkg::CTL_MODE_BIT] & ~trig_nxt;
  wire [15:0] ctl_keep  = (ctl_r & asdl_pkg::CTL_RANGE_MASK)
                        | (16'(keep_mode) << asdl_pkg::CTL_MODE_BIT);
  wire [15:0] ctl_nxt   = wr_ctl ? ctl_wval : ctl_keep;
  wire        mode      = ctl_r[asdl_pkg::CTL_MODE_BIT];

  assign sq.start     = (wr_ctl && !trig_r)
                      || (trig_r && cnv_rise);
  assign sq.halt      = trig_nxt && !trig_r;
  assign sq.repeat_en = ctl_nxt[asdl_pkg::CTL_MODE_BIT];
  assign sq.first_ch  = ctl_nxt[asdl_pkg::CTL_SA_LSB +: asdl_pkg::CH_W];
  assign sq.last_ch   = ctl_nxt[asdl_pkg::CTL_EA_LSB +: asdl_pkg::CH_W];
  assign sq.conv_done = adc_done;
  assign sq.conv_data = adc_data;

  // internal load strobe comes straight from the stored word
  wire internal_load_strobe = (load_r == asdl_pkg::LOAD_MAGIC);
  wire load_any = internal_load_strobe || eld_rise;

  // data-available flag: set wins over every clear
  wire data_avail_flag_set = sq.pass_done && !mode;
  wire data_avail_flag_clr = sq.start || rd_res || mode
                || (wr_stat && !reg_wdata[asdl_pkg::STAT_DATA_AVAIL_FLAG_BIT]);
  wire data_avail_flag_nxt = data_avail_flag_set || (data_avail_flag_r && !data_avail_flag_clr);

  wire       dav_load    = sq.pass_done && mode;
  wire [6:0] dav_cnt_nxt = dav_load ? 7'(asdl_pkg::DAV_CYC)
                         : (dav_cnt_r != 7'h00) ? dav_cnt_r - 7'h01 : 7'h00;
  wire       dav_n_nxt   = mode ? (dav_cnt_nxt == 7'h00) : !data_avail_flag_nxt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_r     <= 16'h0000;
      ctl_r     <= asdl_pkg::CTL_RST;
      load_r    <= 16'h0000;
      trig_r    <= 1'b0;
      data_avail_flag_r    <= 1'b0;
      dav_cnt_r <= 7'h00;
      dav_n_r   <= 1'b1;
    end else begin
      if (wr_cfg) begin
        cfg_r <= reg_wdata;
      end
      if (wr_load) begin
        load_r <= reg_wdata;
      end else if (internal_load_strobe) begin
        load_r <= 16'h0000;
      end
      ctl_r     <= ctl_nxt;
      trig_r    <= trig_nxt;
      data_avail_flag_r    <= data_avail_flag_nxt;
      dav_cnt_r <= dav_cnt_nxt;
      dav_n_r   <= dav_n_nxt;
    end
  end

  assign dac_buffer_gain_sel = cfg_r[asdl_pkg::CFG_GAIN_LSB +: NDAC];
  assign data_avail_n        = dav_n_r;

  // ==========================================================================
  // dac data registers and output latches
  logic [11:0] dac_data_r  [NDAC];
  logic [11:0] dac_latch_r [NDAC];

  for (genvar i = 0; i < NDAC; i++) begin : g_dac
    wire hit = wr_dac && (reg_addr[2:0] == 3'(i));
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        dac_data_r[i]  <= 12'h000;
        dac_latch_r[i] <= 12'h000;
      end else begin
        if (hit) begin
          dac_data_r[i] <= reg_wdata[11:0];
        end
        if (hit && !sld[i]) begin
          dac_latch_r[i] <= reg_wdata[11:0];
        end else if (sld[i] && load_any) begin
          dac_latch_r[i] <= dac_data_r[i];
        end
      end
    end
    assign dac_latch_out[i*12 +: 12] = dac_latch_r[i];
  end

  // ==========================================================================
  // result staging and result registers, channel 8 is the temperature sensor
  // tag reads zero until a result has landed, so every result word resets to zero
  logic [11:0] stg_r  [NCH];
  logic [11:0] res_r  [NCH];
  logic        seen_r [NCH];
  logic        tag_r  [NCH];

  for (genvar c = 0; c < NCH; c++) begin : g_res
    wire smp_hit = sq.smp_valid && (sq.smp_ch == 4'(c));
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        stg_r[c]  <= 12'h000;
        res_r[c]  <= 12'h000;
        seen_r[c] <= 1'b0;
        tag_r[c]  <= 1'b0;
      end else begin
        if (smp_hit) begin
          stg_r[c]  <= sq.smp_data;
          seen_r[c] <= 1'b1;
        end
        if (sq.pass_done) begin
          res_r[c] <= smp_hit ? sq.smp_data : stg_r[c];
          tag_r[c] <= smp_hit || seen_r[c];
        end
      end
    end
  end

  assign adc_start           = sq.conv_start;
  assign adc_channel         = sq.conv_ch;
  assign temp_sensor_channel = (sq.conv_ch == asdl_pkg::CH_TEMP);

  // ==========================================================================
  // read mux
  wire [3:0]  ridx      = reg_addr[3:0];
  wire [3:0]  rtag      = tag_r[ridx] ? ridx : 4'h0;
  wire [15:0] res_word  = {rtag, res_r[ridx]};
  wire [15:0] dac_word  = {1'b0, reg_addr[2:0], dac_latch_r[reg_addr[2:0]]};
  wire [15:0] stat_word = (16'(trig_r) << asdl_pkg::STAT_TRIG_BIT)
                        | (16'(data_avail_flag_r) << asdl_pkg::STAT_DATA_AVAIL_FLAG_BIT);
  wire [15:0] rd_mux    = res_hit                           ? res_word
                        : dac_hit                           ? dac_word
                        : (reg_addr == asdl_pkg::A_DAC_CFG) ? cfg_r
                        : (reg_addr == asdl_pkg::A_STATUS)  ? stat_word
                        : (reg_addr == asdl_pkg::A_ADC_CTL) ? ctl_r
                        : (reg_addr == asdl_pkg::A_LOAD)    ? load_r
                        : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_load_magic;
    wr_load && reg_wdata == asdl_pkg::LOAD_MAGIC |=> internal_load_strobe;
  endproperty
  a_load_magic: assert property (p_load_magic) else $error("magic word gave no strobe");

  property p_load_other;
    wr_load && reg_wdata != asdl_pkg::LOAD_MAGIC |=> !internal_load_strobe;
  endproperty
  a_load_other: assert property (p_load_other) else $error("strobe from other word");

  property p_load_clear;
    internal_load_strobe && !wr_load |=> load_r == 16'h0000 && !internal_load_strobe;
  endproperty
  a_load_clear: assert property (p_load_clear) else $error("load word not cleared");

  property p_sync_copy;
    internal_load_strobe && sld[4] && !(wr_dac && reg_addr[2:0] == 3'h4)
      |=> dac_latch_r[4] == $past(dac_data_r[4]);
  endproperty
  a_sync_copy: assert property (p_sync_copy) else $error("sync latch not loaded");

  property p_async_write;
    wr_dac && reg_addr[2:0] == 3'h0 && !sld[0] |=> dac_latch_r[0] == $past(reg_wdata[11:0]);
  endproperty
  a_async_write: assert property (p_async_write) else $error("async latch not written");

  property p_int_start;
    wr_ctl && !trig_r
      |=> adc_start && adc_channel == $past(reg_wdata[asdl_pkg::CTL_SA_LSB +: 4]);
  endproperty
  a_int_start: assert property (p_int_start) else $error("control write did not start");

  property p_ext_nostart;
    wr_ctl && trig_r && !cnv_rise && !sq.busy |=> !sq.busy;
  endproperty
  a_ext_nostart: assert property (p_ext_nostart) else $error("control write started");

  property p_mode_forced;
    trig_r |-> !mode;
  endproperty
  a_mode_forced: assert property (p_mode_forced) else $error("repeat with external trigger");

  sequence s_dav_low;
    !data_avail_n [*8];
  endsequence
  property p_dav_pulse;
    sq.pass_done && mode && !wr_ctl && !wr_stat |=> s_dav_low;
  endproperty
  a_dav_pulse: assert property (p_dav_pulse) else $error("data-available pulse short");

  property p_hold_result;
    sq.smp_valid && sq.smp_ch == 4'h0 && !sq.pass_done |=> res_r[0] == $past(res_r[0]);
  endproperty
  a_hold_result: assert property (p_hold_result) else $error("result updated early");
endmodule

// ==== bench/asdl_conv_model.sv ====
/*
 * asdl_conv_model: behavioural converter on the far side of the sequencer.
 * assumes one adc_start at a time on sys_clk; answer delay and data salt set by the bench.
 */
`timescale 1ns/1ps
module asdl_conv_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        adc_start,
  input  wire logic [3:0]  adc_channel,
  input  wire logic [7:0]  lat,
  input  wire logic [7:0]  salt,
  output logic             adc_done,
  output logic      [11:0] adc_data
);
  logic [7:0] cnt_r;
  logic       busy_r;
  logic [3:0] ch_r;
  // ==========================================================================
  // answer after lat+1 cycles; data toggles outside the done cycle
  always_ff @(posedge sys_clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (rst) begin
      busy_r   <= 1'b0;
      adc_data <= 12'h000;
    end else if (adc_start) begin
      busy_r <= 1'b1;
      cnt_r  <= lat;
      ch_r   <= adc_channel;
    end else if (busy_r && cnt_r == 8'h00) begin
      busy_r   <= 1'b0;
      adc_done <= 1'b1;
      adc_data <= {ch_r, 8'h3C} ^ {4'h0, salt};
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule

// ==== bench/tb_asdl_top.sv ====
/*
 * tb_asdl_top: register-level tests of the dac load and adc sequencing block.
 * assumes the design package and the converter model are compiled first.
 */
`timescale 1ns/1ps
module tb_asdl_top;
  logic         sys_clk, rst, reg_wr, reg_rd, convert_in, ext_load_in;
  logic [5:0]   reg_addr;
  logic [15:0]  reg_wdata, reg_rdata;
  logic         reg_rvalid, adc_start, temp_sensor_channel, adc_done, data_avail_n;
  logic [95:0]  dac_latch_out, exp_lat;
  logic [7:0]   dac_buffer_gain_sel, lat, salt;
  logic [3:0]   adc_channel;
  logic [11:0]  adc_data;
  logic [3:0]   q[$];
  int           err_count, n_checks, n;

  asdl_top asdl_top_i (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .convert_in(convert_in), .ext_load_in(ext_load_in),
    .dac_latch_out(dac_latch_out), .dac_buffer_gain_sel(dac_buffer_gain_sel),
    .adc_start(adc_start), .adc_channel(adc_channel),
    .temp_sensor_channel(temp_sensor_channel), .adc_done(adc_done), .adc_data(adc_data),
    .data_avail_n(data_avail_n));
  asdl_conv_model asdl_conv_model_i (.sys_clk(sys_clk), .rst(rst), .adc_start(adc_start),
    .adc_channel(adc_channel), .lat(lat), .salt(salt), .adc_done(adc_done),
    .adc_data(adc_data));

  // ==========================================================================
  // helpers
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] e);
    n_checks++;
    if (seen !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e, input string nm);
    @(negedge sys_clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    chk({nm, " valid"}, reg_rvalid, 1'b1);
    chk(nm, reg_rdata, e);
    reg_rd = 1'b0;
  endtask

  task automatic wait_dav();
    int k;
    k = 0;
    while (data_avail_n !== 1'b0 && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
    chk("dav wait", k < 3000, 1'b1);
  endtask

  function automatic logic [15:0] expd(input logic [3:0] ch, input logic [7:0] s);
    return {ch, {ch, 8'h3C} ^ {4'h0, s}};
  endfunction

  // ==========================================================================
  // clock, watchdog, conversion monitor
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    #1_000_000;
    err_count++;
    conclude();
  end

  always @(posedge sys_clk) begin
    if (!rst && adc_start) begin
      q.push_back(adc_channel);
      chk("temp flag", temp_sensor_channel, adc_channel == 4'h8);
    end
  end

  // ==========================================================================
  // tests
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 6'h00; reg_wdata = 16'h0000;
    convert_in = 1'b0; ext_load_in = 1'b0; lat = 8'd10; salt = 8'h5A;
    err_count = 0; n_checks = 0; exp_lat = '0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    chk("dav idle", data_avail_n, 1'b1);
    chk("gain rst", dac_buffer_gain_sel, 8'h00);
    rd(asdl_pkg::A_ADC_CTL, 16'h0000, "ctl rst");
    rd(asdl_pkg::A_LOAD, 16'h0000, "load rst");
    for (int i = 0; i < 9; i++) rd(6'(i), 16'h0000, "res rst");
    rd(6'h3F, 16'h0000, "unmapped");
    // dac gain and load strobes
    wr(asdl_pkg::A_DAC_CFG, 16'hF0A5);
    chk("gain", dac_buffer_gain_sel, 8'hA5);
    for (int i = 0; i < 8; i++) begin
      wr(6'(asdl_pkg::A_DAC0 + i), 16'h0100 + 16'(i));
      if (i < 4) exp_lat[i*12 +: 12] = 12'h100 + 12'(i);
    end
    chk("async latch", dac_latch_out, exp_lat);
    wr(asdl_pkg::A_LOAD, 16'h1234);
    repeat (3) @(negedge sys_clk);
    chk("no strobe", dac_latch_out, exp_lat);
    rd(asdl_pkg::A_LOAD, 16'h1234, "load kept");
    wr(asdl_pkg::A_LOAD, asdl_pkg::LOAD_MAGIC);
    repeat (3) @(negedge sys_clk);
    for (int i = 4; i < 8; i++) exp_lat[i*12 +: 12] = 12'h100 + 12'(i);
    chk("int strobe", dac_latch_out, exp_lat);
    rd(asdl_pkg::A_LOAD, 16'h0000, "load clr");
    wr(6'(asdl_pkg::A_DAC0 + 4), 16'h0777);
    ext_load_in = 1'b1;
    repeat (8) @(negedge sys_clk);
    ext_load_in = 1'b0;
    exp_lat[48 +: 12] = 12'h777;
    chk("ext strobe", dac_latch_out, exp_lat);
    // one-shot internal pass over channels 0..3
    q.delete();
    wr(asdl_pkg::A_ADC_CTL, 16'h0030);
    repeat (20) @(negedge sys_clk);
    rd(6'h00, 16'h0000, "res early");
    wait_dav();
    repeat (100) @(negedge sys_clk);
    chk("pass len", q.size(), 4);
    if (q.size() == 4) chk("pass order", {q[0], q[1], q[2], q[3]}, 16'h0123);
    wr(6'h00, 16'hFFFF);
    for (int i = 0; i < 9; i++)
      rd(6'(i), i < 4 ? expd(4'(i), salt) : 16'h0000, "res");
    // external trigger pass 7..8
    salt = 8'hC3;
    wr(asdl_pkg::A_STATUS, 16'h0020);
    wr(asdl_pkg::A_ADC_CTL, 16'h8780);
    rd(asdl_pkg::A_ADC_CTL, 16'h0780, "ctl ext");
    q.delete();
    repeat (20) @(negedge sys_clk);
    chk("no start", q.size(), 0);
    convert_in = 1'b1;
    wait_dav();
    convert_in = 1'b0;
    chk("ext len", q.size(), 2);
    if (q.size() == 2) chk("ext order", {q[0], q[1]}, 8'h78);
    rd(6'h08, expd(4'h8, 8'hC3), "res8");
    rd(6'h03, expd(4'h3, 8'h5A), "res3 kept");
    // repeating mode 0..1
    lat = 8'd60;
    q.delete();
    wr(asdl_pkg::A_STATUS, 16'h0000);
    wr(asdl_pkg::A_ADC_CTL, 16'h8010);
    wait_dav();
    n = 0;
    while (data_avail_n === 1'b0 && n < 200) begin
      n++;
      @(negedge sys_clk);
    end
    chk("dav pulse", n, asdl_pkg::DAV_CYC);
    n = 0;
    while (q.size() < 6 && n < 2000) begin
      n++;
      @(negedge sys_clk);
    end
    if (q.size() >= 6) chk("repeat order", {q[0], q[1], q[2], q[3], q[4], q[5]}, 24'h010101);
    else chk("repeat len", q.size(), 6);
    wr(asdl_pkg::A_ADC_CTL, 16'h0010);
    repeat (300) @(negedge sys_clk);
    q.delete();
    repeat (300) @(negedge sys_clk);
    chk("stop oneshot", q.size(), 0);
    wr(asdl_pkg::A_ADC_CTL, 16'h8010);
    repeat (50) @(negedge sys_clk);
    wr(asdl_pkg::A_STATUS, 16'h0020);
    repeat (300) @(negedge sys_clk);
    q.delete();
    repeat (300) @(negedge sys_clk);
    chk("stop ext", q.size(), 0);
    rd(asdl_pkg::A_ADC_CTL, 16'h0010, "repeat clr");
    conclude();
  end
endmodule
